// file: common/tmr_defs.vh
// constants for the timer set: register indices, field positions, timing
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH
`define TMR_AW 4
`define TMR_DW 16
// register indices
`define TMR_A_CON1 4'h0
`define TMR_A_CNT1 4'h1
`define TMR_A_PER1 4'h2
`define TMR_A_CON2 4'h3
`define TMR_A_CNT2 4'h4
`define TMR_A_PER2 4'h5
`define TMR_A_CON3 4'h6
`define TMR_A_CNT3 4'h7
`define TMR_A_PER3 4'h8
`define TMR_A_FLAG 4'h9
`define TMR_A_IEN 4'hA
// control fields
`define TMR_B_RUN 15
`define TMR_B_IDLE 13
`define TMR_B_GATE 6
`define TMR_B_PSH 5
`define TMR_B_PSL 4
`define TMR_B_CHAIN 3
`define TMR_B_SYNC 2
`define TMR_B_CS 1
// writable masks per control register
`define TMR_M_CON1 16'hA076
`define TMR_M_CON2 16'hA07A
`define TMR_M_CON3 16'hA072
`define TMR_RST 16'h0000
`define TMR_PER_RST 16'hFFFF
// prescale terminal counts (ratio minus one)
`define TMR_PS_1 8'h00
`define TMR_PS_8 8'h07
`define TMR_PS_64 8'h3F
`define TMR_PS_256 8'hFF
// flag and enable bit positions
`define TMR_F_T1 0
`define TMR_F_T2 1
`define TMR_F_T3 2
`endif

// file: verilog/tmr_unit.v
// one 16-bit timer channel: prescaler, tick qualifier, counter, match
`timescale 1ns/1ps
`include "tmr_defs.vh"
module tmr_unit (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // control
    input wire [15:0] con_in,
    input wire con_wr_in,
    input wire idle_in,
    input wire ext_edge_in,
    input wire gate_in,
    input wire carry_mode_in,
    input wire carry_in,
    // count load
    input wire load_in,
    input wire [15:0] load_val_in,
    input wire [15:0] period_in,
    input wire clear_in,
    // results
    output reg [15:0] count_out,
    output wire tick_out,
    output wire match_out
);
    reg [7:0] pre_q;
    reg [7:0] term;
    wire run;
    wire src_ok;
    wire raw_tick;

    // prescale code to terminal count
    always @* begin
        case (con_in[`TMR_B_PSH:`TMR_B_PSL])
            2'b00: term = `TMR_PS_1;
            2'b01: term = `TMR_PS_8;
            2'b10: term = `TMR_PS_64;
            default: term = `TMR_PS_256;
        endcase
    end

    assign run = con_in[`TMR_B_RUN] &
        ~(con_in[`TMR_B_IDLE] & idle_in);
    // gate is ignored on external clock; internal source feeds the prescaler every cycle unless gating is on and gate_in is low
    assign src_ok = con_in[`TMR_B_CS] ? ext_edge_in :
        (~con_in[`TMR_B_GATE] | gate_in);
    assign raw_tick = run & src_ok & (pre_q == term);
    assign tick_out = carry_mode_in ? carry_in : raw_tick;
    assign match_out = (count_out == period_in);

    // prescaler restarts on stop or control write for a full first period
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre_q <= 8'h00;
        end else if (!run || con_wr_in) begin
            pre_q <= 8'h00;
        end else if (src_ok) begin
            pre_q <= (pre_q == term) ? 8'h00 : pre_q + 8'h01;
        end
    end

    // counter: load, period wrap, or increment
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_out <= `TMR_RST;
        end else if (load_in) begin
            count_out <= load_val_in;
        end else if (tick_out) begin
            if (clear_in) begin
                count_out <= `TMR_RST;
            end else begin
                count_out <= count_out + 16'h0001;
            end
        end
    end
endmodule // tmr_unit

// file: verilog/tmr_top.v
// timer set top: register port, three timers, chaining, flags, outputs
`timescale 1ns/1ps
`include "tmr_defs.vh"
module tmr_top (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // register port
    input wire [3:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [15:0] rdata_out,
    // device state and pins
    input wire idle_in,
    input wire standalone_ext_clock_pin_in,
    input wire lower_ext_clock_pin_in,
    input wire upper_ext_clock_pin_in,
    input wire gate1_in,
    input wire gate2_in,
    input wire gate3_in,
    // events and time bases
    output reg standalone_irq_out,
    output reg lower_irq_out,
    output reg upper_irq_out,
    output reg conv_trigger_out,
    output reg [15:0] lower_timebase_out,
    output reg [15:0] upper_timebase_out
);
    reg [15:0] con1_q;
    reg [15:0] con2_q;
    reg [15:0] con3_q;
    reg [15:0] per1_q;
    reg [15:0] per2_q;
    reg [15:0] per3_q;
    reg [2:0] flag_q;
    reg [2:0] ien_q;
    reg [2:0] pin1_q;
    reg [2:0] pin2_q;
    reg [2:0] pin3_q;
    reg g1_q;
    reg g1_d;
    reg g2_q;
    reg g3_q;
    reg [2:0] evt;
    wire [15:0] cnt1;
    wire [15:0] cnt2;
    wire [15:0] cnt3;
    wire tick1;
    wire tick2;
    wire tick3;
    wire m1;
    wire m2;
    wire m3;
    wire chain;
    wire [15:0] con3_eff;
    wire e1_sync;
    wire e1_async;
    wire e1;
    wire e2;
    wire e3;
    wire wr_cnt1;
    wire match32;

    // true when a write targets the given register index
    function wr_hit;
        input [3:0] a;
        input [3:0] idx;
        input w;
        begin
            wr_hit = w && (a == idx);
        end
    endfunction

    assign chain = con2_q[`TMR_B_CHAIN];
    // in chained mode upper timer runs off lower control entirely
    assign con3_eff = chain ? `TMR_RST : con3_q;

    // pin samples: two stages then an edge stage; pins arrive synchronous,
    // so the async mode may tap stage 0 and save a cycle of latency
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin1_q <= 3'h0;
            pin2_q <= 3'h0;
            pin3_q <= 3'h0;
            g1_q <= 1'b0;
            g2_q <= 1'b0;
            g3_q <= 1'b0;
            g1_d <= 1'b0;
        end else begin
            pin1_q <= {pin1_q[1:0], standalone_ext_clock_pin_in};
            pin2_q <= {pin2_q[1:0], lower_ext_clock_pin_in};
            pin3_q <= {pin3_q[1:0], upper_ext_clock_pin_in};
            g1_q <= gate1_in;
            g2_q <= gate2_in;
            g3_q <= gate3_in;
            g1_d <= g1_q;
        end
    end

    // async mode skips the extra sync stage, so it sees edges a cycle sooner
    assign e1_sync = pin1_q[1] & ~pin1_q[2];
    assign e1_async = pin1_q[0] & ~pin1_q[1];
    assign e1 = con1_q[`TMR_B_SYNC] ? e1_sync : e1_async;
    assign e2 = pin2_q[1] & ~pin2_q[2];
    assign e3 = pin3_q[1] & ~pin3_q[2];

    // count writes to standalone are blocked while external and running
    assign wr_cnt1 = wr_hit(addr_in, `TMR_A_CNT1, wr_in) &
        ~(con1_q[`TMR_B_CS] & con1_q[`TMR_B_RUN]);
    assign match32 = m2 & m3;

    tmr_unit u_t1 (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .con_in(con1_q),
        .con_wr_in(wr_hit(addr_in, `TMR_A_CON1, wr_in)),
        .idle_in(idle_in),
        .ext_edge_in(e1),
        .gate_in(g1_q),
        .carry_mode_in(1'b0),
        .carry_in(1'b0),
        .load_in(wr_cnt1),
        .load_val_in(wdata_in),
        .period_in(per1_q),
        .clear_in(m1),
        .count_out(cnt1),
        .tick_out(tick1),
        .match_out(m1)
    );

    // when chained, lower word clears on full 32-bit match, not on its own period, and still rolls over from FFFF
    tmr_unit u_t2 (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .con_in(con2_q),
        .con_wr_in(wr_hit(addr_in, `TMR_A_CON2, wr_in)),
        .idle_in(idle_in),
        .ext_edge_in(e2),
        .gate_in(g2_q),
        .carry_mode_in(1'b0),
        .carry_in(1'b0),
        .load_in(wr_hit(addr_in, `TMR_A_CNT2, wr_in)),
        .load_val_in(wdata_in),
        .period_in(per2_q),
        .clear_in(chain ? match32 : m2),
        .count_out(cnt2),
        .tick_out(tick2),
        .match_out(m2)
    );

    // upper word steps on lower carry when chained
    tmr_unit u_t3 (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .con_in(con3_eff),
        .con_wr_in(wr_hit(addr_in, `TMR_A_CON3, wr_in)),
        .idle_in(idle_in),
        .ext_edge_in(e3),
        .gate_in(g3_q),
        .carry_mode_in(chain),
        .carry_in(tick2 & (match32 | (cnt2 == 16'hFFFF))),
        .load_in(wr_hit(addr_in, `TMR_A_CNT3, wr_in)),
        .load_val_in(wdata_in),
        .period_in(per3_q),
        .clear_in(chain ? match32 : m3),
        .count_out(cnt3),
        .tick_out(tick3),
        .match_out(m3)
    );

    // events: period wrap on tick; standalone also on gate falling edge
    always @* begin
        evt[`TMR_F_T1] = (tick1 & m1) |
            (con1_q[`TMR_B_RUN] & con1_q[`TMR_B_GATE] &
            ~con1_q[`TMR_B_CS] & g1_d & ~g1_q);
        evt[`TMR_F_T2] = tick2 & m2 & ~chain;
        evt[`TMR_F_T3] = chain ? (tick2 & match32) : (tick3 & m3);
    end

    // control and period registers; unimplemented bits stay zero
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            con1_q <= `TMR_RST;
            con2_q <= `TMR_RST;
            con3_q <= `TMR_RST;
            per1_q <= `TMR_PER_RST;
            per2_q <= `TMR_PER_RST;
            per3_q <= `TMR_PER_RST;
            ien_q <= 3'h0;
        end else if (wr_in) begin
            case (addr_in)
                `TMR_A_CON1: con1_q <= wdata_in & `TMR_M_CON1;
                `TMR_A_CON2: con2_q <= wdata_in & `TMR_M_CON2;
                `TMR_A_CON3: con3_q <= wdata_in & `TMR_M_CON3;
                `TMR_A_PER1: per1_q <= wdata_in;
                `TMR_A_PER2: per2_q <= wdata_in;
                `TMR_A_PER3: per3_q <= wdata_in;
                `TMR_A_IEN: ien_q <= wdata_in[2:0];
                default: ien_q <= ien_q;
            endcase
        end
    end

    // sticky flags: write one to clear, a new event wins over the clear
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_q <= 3'h0;
        end else if (wr_hit(addr_in, `TMR_A_FLAG, wr_in)) begin
            flag_q <= (flag_q & ~wdata_in[2:0]) | evt;
        end else begin
            flag_q <= flag_q | evt;
        end
    end

    // outputs all registered; irq lines are flag or new event, gated by enable
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            standalone_irq_out <= 1'b0;
            lower_irq_out <= 1'b0;
            upper_irq_out <= 1'b0;
            conv_trigger_out <= 1'b0;
            lower_timebase_out <= `TMR_RST;
            upper_timebase_out <= `TMR_RST;
        end else begin
            standalone_irq_out <= (flag_q[`TMR_F_T1] | evt[`TMR_F_T1]) &
                ien_q[`TMR_F_T1];
            lower_irq_out <= (flag_q[`TMR_F_T2] | evt[`TMR_F_T2]) &
                ien_q[`TMR_F_T2];
            upper_irq_out <= (flag_q[`TMR_F_T3] | evt[`TMR_F_T3]) &
                ien_q[`TMR_F_T3];
            conv_trigger_out <= chain & tick2 & match32;
            lower_timebase_out <= cnt2;
            upper_timebase_out <= cnt3;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= `TMR_RST;
        end else if (rd_in) begin
            case (addr_in)
                `TMR_A_CON1: rdata_out <= con1_q;
                `TMR_A_CNT1: rdata_out <= cnt1;
                `TMR_A_PER1: rdata_out <= per1_q;
                `TMR_A_CON2: rdata_out <= con2_q;
                `TMR_A_CNT2: rdata_out <= cnt2;
                `TMR_A_PER2: rdata_out <= per2_q;
                `TMR_A_CON3: rdata_out <= con3_q;
                `TMR_A_CNT3: rdata_out <= cnt3;
                `TMR_A_PER3: rdata_out <= per3_q;
                `TMR_A_FLAG: rdata_out <= {13'h0000, flag_q};
                `TMR_A_IEN: rdata_out <= {13'h0000, ien_q};
                default: rdata_out <= `TMR_RST;
            endcase
        end else begin
            rdata_out <= `TMR_RST;
        end
    end
endmodule // tmr_top

// file: verif/tmr_monitor.sv
// checker for the timer set register port and event outputs
`timescale 1ns/1ps
module tmr_monitor (
    // watched ports
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire [3:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [15:0] rdata_out,
    input wire standalone_irq_out,
    input wire conv_trigger_out,
    input wire [15:0] lower_timebase_out,
    input wire [15:0] upper_timebase_out
);
    reg [15:0] con2_q;
    reg [2:0] ien_q;
    reg [1:0] still_q;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // write shadows; still_q waits out the time base pipeline after a stop
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            con2_q <= 16'h0000;
            ien_q <= 3'h0;
            still_q <= 2'h0;
        end else begin
            if (wr_in && addr_in == 4'h3) con2_q <= wdata_in;
            if (wr_in && addr_in == 4'hA) ien_q <= wdata_in[2:0];
            if (con2_q[15] || (wr_in && addr_in[3:1] == 3'h2))
                still_q <= 2'h0;
            else if (still_q != 2'h3)
                still_q <= still_q + 2'h1;
        end
    end
    a_rdata_quiet:
    assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data outside its cycle");
    a_unmapped_zero:
    assert property (rd_in && addr_in > 4'hA |=> rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    a_con1_bits:
    assert property (rd_in && addr_in == 4'h0 |=> !(rdata_out & 16'h5F89))
        else $error("standalone control spare bit set");
    a_con2_bits:
    assert property (rd_in && addr_in == 4'h3 |=> !(rdata_out & 16'h5F85))
        else $error("lower control spare bit set");
    a_con3_bits:
    assert property (rd_in && addr_in == 4'h6 |=> !(rdata_out & 16'h5F8D))
        else $error("upper control spare bit set");
    a_con2_back:
    assert property (wr_in && addr_in == 4'h3
        ##1 !(wr_in && addr_in == 4'h3) ##1 rd_in && addr_in == 4'h3
        |=> rdata_out == ($past(wdata_in, 3) & 16'hA07A))
        else $error("lower control readback wrong");
    // a zero period matches on every tick, so only a nonzero one must pulse
    a_trig_pulse:
    assert property (conv_trigger_out &&
        {upper_timebase_out, lower_timebase_out} != 32'h0000_0000
        |=> !conv_trigger_out)
        else $error("trigger longer than one cycle");
    a_trig_chained:
    assert property (conv_trigger_out |-> $past(con2_q[3]))
        else $error("trigger while not chained");
    a_irq_enabled:
    assert property (standalone_irq_out |-> $past(ien_q[0]))
        else $error("standalone irq while disabled");
    a_stop_holds:
    assert property (still_q == 2'h3 |-> $stable(lower_timebase_out))
        else $error("lower count moved while stopped");
    c_trig: cover property (conv_trigger_out);
    c_irq: cover property (standalone_irq_out);
    c_unmapped: cover property (rd_in && addr_in > 4'hA);
endmodule // tmr_monitor
bind tmr_top tmr_monitor u_mon (.sys_clk_in, .rst_n_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .standalone_irq_out,
    .conv_trigger_out, .lower_timebase_out, .upper_timebase_out);

// file: verif/testbench.sv
// self-checking bench for the timer set
`timescale 1ns/1ps
module testbench;
    reg sys_clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg [3:0] addr_in = 4'h0;
    reg [15:0] wdata_in = 16'h0000;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    reg idle_in = 1'b0;
    reg [2:0] pin = 3'h0;
    reg [2:0] gate = 3'h0;
    wire [15:0] rdata_out, tb_lo, tb_hi;
    wire irq1, irq2, irq3, trig;
    wire [3:0] ev = {irq2, trig, irq3, irq1};
    integer miscompares = 0;
    integer num_checks = 0;
    integer seed = 25207;
    integer i, j, k, n, r, t = 0;
    reg [15:0] v, w;
    always #10 sys_clk_in = ~sys_clk_in;
    tmr_top dut (.sys_clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
        .rd_in, .rdata_out, .idle_in,
        .standalone_ext_clock_pin_in(pin[0]),
        .lower_ext_clock_pin_in(pin[1]), .upper_ext_clock_pin_in(pin[2]),
        .gate1_in(gate[0]), .gate2_in(gate[1]), .gate3_in(gate[2]),
        .standalone_irq_out(irq1), .lower_irq_out(irq2),
        .upper_irq_out(irq3), .conv_trigger_out(trig),
        .lower_timebase_out(tb_lo), .upper_timebase_out(tb_hi));
    task chk(input [15:0] s, input [15:0] e);
        begin
            num_checks = num_checks + 1;
            if (s !== e) begin
                miscompares = miscompares + 1;
                $display("Error %0t seen %h expected %h", $time, s, e);
            end
        end
    endtask
    // one-cycle write strobe, then one idle cycle
    task wrr(input [3:0] a, input [15:0] d);
        begin
            @(posedge sys_clk_in);
            addr_in <= a;
            wdata_in <= d;
            wr_in <= 1'b1;
            @(posedge sys_clk_in);
            wr_in <= 1'b0;
        end
    endtask
    // read data stands only in the cycle after the strobe
    task rdr(input [3:0] a, output [15:0] d);
        begin
            @(posedge sys_clk_in);
            addr_in <= a;
            rd_in <= 1'b1;
            @(posedge sys_clk_in);
            rd_in <= 1'b0;
            @(negedge sys_clk_in);
            d = rdata_out;
        end
    endtask
    task rc(input [3:0] a, input [15:0] e);
        reg [15:0] d;
        begin
            rdr(a, d);
            chk(d, e);
        end
    endtask
    // bounded wait for one event output
    task wev(input integer s);
        begin
            k = 0;
            while (ev[s] !== 1'b1 && k < 40) begin
                @(negedge sys_clk_in);
                k = k + 1;
            end
            chk({15'h0, ev[s]}, 16'h0001);
        end
    endtask
    // pin high for four cycles and low for five, slow enough to synchronise
    task pulse(input integer p, input integer c);
        repeat (c) begin
            @(posedge sys_clk_in);
            pin[p] <= 1'b1;
            repeat (4) @(posedge sys_clk_in);
            pin[p] <= 1'b0;
            repeat (4) @(posedge sys_clk_in);
        end
    endtask
    task tdone;
        begin
            t = t + 1;
            $display("test %0d done", t);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // watchdog well beyond the under two thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        miscompares = miscompares + 1;
        report_and_stop;
    end
    initial begin
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        // reset values, index 11 unmapped
        for (i = 0; i < 12; i = i + 1) begin
            v = (i % 3 == 2 && i < 9) ? 16'hFFFF : 16'h0000;
            rc(i[3:0], v);
        end
        for (i = 0; i < 3; i = i + 1) begin
            k = 3 * i;
            v = i == 0 ? 16'hA076 : i == 1 ? 16'hA07A : 16'hA072;
            wrr(k[3:0], 16'hFFFF);
            rc(k[3:0], v);
            wrr(k[3:0], 16'h0000);
        end
        for (i = 1; i < 9; i = i + 3) wrr(i[3:0], 16'h0000);
        wrr(4'h9, 16'h0007);
        tdone;
        // stop half way through a prescaled tick: count is exact
        for (i = 1; i < 4; i = i + 1) begin
            r = i == 1 ? 8 : i == 2 ? 64 : 256;
            n = 3 * r + r / 2 - 2;
            wrr(4'h1, 16'h0000);
            wrr(4'h0, {10'h200, i[1:0], 4'h0});
            repeat (n) @(posedge sys_clk_in);
            wrr(4'h0, 16'h0000);
            v = (n + 2) / r;
            rc(4'h1, v);
        end
        wrr(4'h2, 16'h0004);
        wrr(4'hA, 16'h0001);
        wrr(4'h0, 16'h8000);
        wev(0);
        wrr(4'h0, 16'h0000);
        rc(4'h9, 16'h0001);
        rdr(4'h1, v);
        chk({15'h0, v <= 16'h0004}, 16'h0001);
        wrr(4'h9, 16'h0001);
        rc(4'h9, 16'h0000);
        tdone;
        // gated accumulation and the gate's falling edge event
        wrr(4'h2, 16'hFFFF);
        wrr(4'h1, 16'h0000);
        wrr(4'h0, 16'h8040);
        n = 10 + $unsigned($random(seed)) % 16;
        gate[0] <= 1'b1;
        repeat (n) @(posedge sys_clk_in);
        gate[0] <= 1'b0;
        repeat (6) @(posedge sys_clk_in);
        rc(4'h9, 16'h0001);
        rdr(4'h1, v);
        chk(v, n[15:0]);
        rc(4'h1, v);
        wrr(4'h0, 16'h0000);
        wrr(4'h9, 16'h0007);
        wrr(4'h1, 16'h0000);
        wrr(4'h0, 16'h8002);
        wrr(4'h1, 16'h1234);
        rc(4'h1, 16'h0000);
        tdone;
        // pin edges on each timer; timer 1 synchronised, then not
        for (i = 0; i < 4; i = i + 1) begin
            j = i % 3;
            k = 3 * j;
            wrr(k[3:0], 16'h0000);
            wrr(k[3:0] + 4'h1, 16'h0000);
            wrr(k[3:0], i == 0 ? 16'h8006 : 16'h8002);
            n = 1 + $unsigned($random(seed)) % 8;
            pulse(j, n);
            wrr(k[3:0], 16'h0000);
            rc(k[3:0] + 4'h1, n[15:0]);
            if (j == 1) chk(tb_lo, n[15:0]);
            if (j == 2) chk(tb_hi, n[15:0]);
        end
        tdone;
        wrr(4'h3, 16'hA000);
        idle_in <= 1'b1;
        rdr(4'h4, v);
        repeat (8) @(posedge sys_clk_in);
        rc(4'h4, v);
        wrr(4'h3, 16'h8000);
        rdr(4'h4, v);
        rdr(4'h4, w);
        chk(w - v, 16'h0002);
        // idle stays high into the chained test
        tdone;
        // chained pair in idle: carry into upper word and 32-bit match
        wrr(4'h3, 16'h0000);
        wrr(4'h9, 16'h0007);
        wrr(4'h4, 16'hFFFE);
        wrr(4'h7, 16'h0000);
        wrr(4'h5, 16'h0003);
        wrr(4'h8, 16'h0001);
        wrr(4'hA, 16'h0004);
        wrr(4'h3, 16'h8008);
        wev(2);
        repeat (2) @(negedge sys_clk_in);
        chk({15'h0, irq3}, 16'h0001);
        idle_in <= 1'b0;
        wrr(4'h3, 16'h0000);
        rc(4'h9, 16'h0004);
        rdr(4'h4, v);
        chk(tb_lo, v);
        tdone;
        // lower timer alone: its own period match, its own flag and line
        wrr(4'h9, 16'h0007);
        wrr(4'h4, 16'h0000);
        wrr(4'h5, 16'h0002);
        wrr(4'hA, 16'h0002);
        wrr(4'h3, 16'h8000);
        wev(3);
        chk({15'h0, irq3}, 16'h0000);
        wrr(4'h3, 16'h0000);
        rc(4'h9, 16'h0002);
        tdone;
        report_and_stop;
    end
endmodule // testbench
